// *** design/flash_seq_pkg.sv ***
// package: constants and types for the flash command sequencer host
package flash_seq_pkg;
	// command codes written on the flash data bus
	localparam logic [7:0] CMD_READ_STATUS   = 8'h70;
	localparam logic [7:0] CMD_PROG_SETUP    = 8'h40;
	localparam logic [7:0] CMD_PROG_SETUP_B  = 8'h10;
	localparam logic [7:0] CMD_READ_ARRAY    = 8'hff;
	localparam logic [7:0] CMD_SUSPEND       = 8'hb0;
	localparam logic [7:0] CMD_RESUME        = 8'hd0;
	localparam logic [7:0] CMD_LOCK_SETUP    = 8'h60;
	localparam logic [7:0] CMD_LOCK_BLOCK    = 8'h01;
	localparam logic [7:0] CMD_LOCK_PERM     = 8'hf1;
	localparam logic [7:0] CMD_LOCK_CLEAR    = 8'hd0;
	localparam logic [7:0] CMD_CLEAR_STATUS  = 8'h50;
	// status_reg_bits positions
	localparam int SR_READY    = 7;
	localparam int SR_ERASE    = 5;
	localparam int SR_WRITE    = 4;
	localparam int SR_SUPPLY   = 3;
	localparam int SR_SUSPEND  = 2;
	localparam int SR_PROTECT  = 1;
	// apb register offsets (byte addresses)
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_ADDR    = 8'h04;
	localparam logic [7:0] REG_DATA    = 8'h08;
	localparam logic [7:0] REG_STATUS  = 8'h0c;
	localparam logic [7:0] REG_IRQ_ST  = 8'h10;
	localparam logic [7:0] REG_IRQ_MSK = 8'h14;
	// operation codes written to REG_CTRL[3:0]
	localparam logic [3:0] OP_POLL      = 4'h1;
	localparam logic [3:0] OP_PROGRAM   = 4'h2;
	localparam logic [3:0] OP_SUSPEND   = 4'h3;
	localparam logic [3:0] OP_RESUME    = 4'h4;
	localparam logic [3:0] OP_LOCK_BLK  = 4'h5;
	localparam logic [3:0] OP_LOCK_PERM = 4'h6;
	localparam logic [3:0] OP_LOCK_CLR  = 4'h7;
	localparam logic [3:0] OP_CLR_STAT  = 4'h8;
	localparam logic [3:0] OP_READ      = 4'h9;
	localparam logic [3:0] OP_RAW_CMD   = 4'ha;
	// bus cycle timing in pclk cycles
	localparam logic [3:0] PULSE_CYCLES = 4'd4;
	localparam logic [3:0] RESET_CYCLES = 4'd8;
	// interrupt status bits
	localparam int IRQ_DONE = 0;
	localparam int IRQ_ERR  = 1;
	localparam int IRQ_RDY  = 2;
	localparam int IRQ_W    = 3;

	typedef struct packed {
		logic [22:0] addr;
		logic [15:0] wdata;
		logic        ce_n;
		logic        oe_n;
		logic        we_n;
		logic        dq_oe;
		logic        rp_n;
	} flash_pins_t;
endpackage : flash_seq_pkg

// *** design/flash_host.sv ***
// host side sequencer that drives a parallel nor flash through its pins
// Notes on behaviour
// - poll by writing status-read command, then read; bit 7 one means ready.
// - program is setup command (40 or 10) then data at target address; the host always sends 40.
// - host issues read-array at the start of each read op to return to array mode.
// - on an error in the final status check the host sets IRQ_ERR; the clear-status op or a device reset clears status.
// - suspend pauses program; read-array reads other locations; resume continues the paused count.
// - lock set is setup then confirm 01 block or f1 permanent.
// - clear lock bits is setup 60 then confirm d0; busy on bit 7.
`timescale 1ns/1ps
`default_nettype none
module flash_host
	import flash_seq_pkg::*;
(
	// apb slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// interrupt
	output logic             irq,
	// flash pins
	output logic      [22:0] flash_addr,
	output logic      [15:0] flash_dq_out,
	input  wire logic [15:0] flash_dq_in,
	output logic             flash_dq_oe,
	output logic             flash_ce_n,
	output logic             flash_oe_n,
	output logic             flash_we_n,
	output logic             reset_powerdown_input_n,
	input  wire logic        ready_busy_output
);
	// =========================================================
	// pin synchronisers
	logic [15:0] dq_s1_q, dq_s2_q;
	logic        rb_s1_q, rb_s2_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dq_s1_q <= 16'h0000;
			dq_s2_q <= 16'h0000;
			// idle level of the pulled-up pin, so reset gives no false ready edge
			rb_s1_q <= 1'b1;
			rb_s2_q <= 1'b1;
		end else begin
			dq_s1_q <= flash_dq_in;
			dq_s2_q <= dq_s1_q;
			rb_s1_q <= ready_busy_output;
			rb_s2_q <= rb_s1_q;
		end
	end

	// =========================================================
	// sequencer
	typedef enum logic [7:0] {
		ST_IDLE  = 8'b00000001,
		ST_WR1   = 8'b00000010,
		ST_WR2   = 8'b00000100,
		ST_POLLW = 8'b00001000,
		ST_POLLR = 8'b00010000,
		ST_RD    = 8'b00100000,
		ST_RST   = 8'b01000000,
		ST_GAP   = 8'b10000000
	} seq_state_t;

	seq_state_t  st_q, st_d;
	flash_pins_t pin_q, pin_d;
	logic [3:0]  cnt_q, cnt_d;
	logic [3:0]  op_q, op_d;
	logic [7:0]  cmd2_q, cmd2_d;
	logic        two_q, two_d;
	logic        poll_q, poll_d;
	logic [22:0] addr_q, addr_d;
	logic [15:0] data_q, data_d;
	logic [15:0] rdata_q, rdata_d;
	logic [7:0]  stat_q, stat_d;
	logic        busy_q, busy_d;
	logic        done_ev, err_ev;

	logic        wr_acc;
	assign wr_acc = psel & penable & pwrite;

	// second write cycle carries data, or the confirm code at the target address
	function automatic logic [7:0] confirm_code(input logic [3:0] op);
		case (op)
			OP_LOCK_BLK:  confirm_code = CMD_LOCK_BLOCK;
			OP_LOCK_PERM: confirm_code = CMD_LOCK_PERM;
			OP_LOCK_CLR:  confirm_code = CMD_LOCK_CLEAR;
			default:      confirm_code = 8'h00;
		endcase
	endfunction : confirm_code

	always_comb begin
		st_d    = st_q;
		pin_d   = pin_q;
		cnt_d   = cnt_q;
		op_d    = op_q;
		cmd2_d  = cmd2_q;
		two_d   = two_q;
		poll_d  = poll_q;
		addr_d  = addr_q;
		data_d  = data_q;
		rdata_d = rdata_q;
		stat_d  = stat_q;
		busy_d  = busy_q;
		done_ev = 1'b0;
		err_ev  = 1'b0;
		case (st_q)
			ST_IDLE: begin
				if (wr_acc && paddr == REG_ADDR)
					addr_d = pwdata[22:0];
				if (wr_acc && paddr == REG_DATA)
					data_d = pwdata[15:0];
				if (wr_acc && paddr == REG_CTRL && pwdata[3:0] != 4'h0) begin
					op_d   = pwdata[3:0];
					busy_d = 1'b1;
					cnt_d  = 4'd0;
					two_d  = 1'b0;
					poll_d = 1'b1;
					cmd2_d = confirm_code(pwdata[3:0]);
					st_d   = ST_WR1;
					pin_d.addr  = 23'h000000;
					pin_d.wdata = 16'h0000;
					case (pwdata[3:0])
						OP_POLL:      pin_d.wdata = {8'h00, CMD_READ_STATUS};
						OP_PROGRAM: begin
							pin_d.wdata = {8'h00, CMD_PROG_SETUP};
							two_d = 1'b1;
						end
						OP_SUSPEND:   pin_d.wdata = {8'h00, CMD_SUSPEND};
						OP_RESUME: begin
							pin_d.wdata = {8'h00, CMD_RESUME};
							poll_d = 1'b0;
						end
						OP_LOCK_BLK, OP_LOCK_PERM, OP_LOCK_CLR: begin
							pin_d.wdata = {8'h00, CMD_LOCK_SETUP};
							two_d = 1'b1;
						end
						OP_CLR_STAT: begin
							pin_d.wdata = {8'h00, CMD_CLEAR_STATUS};
							poll_d = 1'b0;
						end
						OP_READ: begin
							// read-array first, then a read cycle at the given address
							pin_d.wdata = {8'h00, CMD_READ_ARRAY};
							poll_d = 1'b0;
						end
						OP_RAW_CMD: begin
							pin_d.wdata = {8'h00, pwdata[15:8]};
							poll_d = 1'b0;
						end
						default: begin
							busy_d = 1'b0;
							st_d   = ST_IDLE;
						end
					endcase
					if (st_d == ST_WR1) begin
						pin_d.ce_n  = 1'b0;
						pin_d.we_n  = 1'b0;
						pin_d.dq_oe = 1'b1;
					end
				end
			end
			ST_WR1, ST_WR2, ST_POLLW: begin
				cnt_d = cnt_q + 4'd1;
				if (cnt_q == PULSE_CYCLES - 4'd1) begin
					pin_d.we_n  = 1'b1;
					pin_d.ce_n  = 1'b1;
					cnt_d = 4'd0;
					st_d  = ST_GAP;
				end
			end
			ST_GAP: begin
				pin_d.dq_oe = 1'b0;
				pin_d.ce_n  = 1'b0;
				pin_d.addr  = 23'h000000;
				if (two_q) begin
					two_d = 1'b0;
					pin_d.we_n  = 1'b0;
					pin_d.dq_oe = 1'b1;
					pin_d.addr  = addr_q;
					pin_d.wdata = (op_q == OP_PROGRAM) ? data_q : {8'h00, cmd2_q};
					st_d = ST_WR2;
				end else if (poll_q) begin
					// only the first status read is preceded by a fresh status command; a not-ready retry reads again directly
					pin_d.we_n  = 1'b0;
					pin_d.dq_oe = 1'b1;
					pin_d.wdata = {8'h00, CMD_READ_STATUS};
					poll_d = 1'b0;
					st_d = ST_POLLW;
				end else if (op_q == OP_READ || st_q == ST_GAP && op_q == OP_POLL) begin
					pin_d.oe_n = 1'b0;
					pin_d.addr = (op_q == OP_READ) ? addr_q : 23'h000000;
					st_d = ST_RD;
				end else if (op_q == OP_PROGRAM || op_q == OP_SUSPEND || op_q >= OP_LOCK_BLK && op_q <= OP_LOCK_PERM
				             || op_q == OP_LOCK_CLR) begin
					pin_d.oe_n = 1'b0;
					st_d = ST_POLLR;
				end else begin
					pin_d.ce_n = 1'b1;
					if (op_q == OP_CLR_STAT)
						stat_d = 8'h00;
					busy_d  = 1'b0;
					done_ev = 1'b1;
					st_d    = ST_IDLE;
				end
			end
			ST_POLLR, ST_RD: begin
				cnt_d = cnt_q + 4'd1;
				if (cnt_q == PULSE_CYCLES - 4'd1) begin
					cnt_d = 4'd0;
					pin_d.oe_n = 1'b1;
					pin_d.ce_n = 1'b1;
					rdata_d = dq_s2_q;
					// array reads leave the stored status alone
					if (op_q == OP_POLL)
						stat_d = dq_s2_q[7:0];
					if (st_q == ST_RD) begin
						busy_d  = 1'b0;
						done_ev = 1'b1;
						st_d    = ST_IDLE;
					end else if (!dq_s2_q[SR_READY]) begin
						st_d = ST_GAP;
					end else begin
						// errors only trusted once ready is seen
						stat_d  = dq_s2_q[7:0];
						err_ev  = dq_s2_q[SR_WRITE] | dq_s2_q[SR_ERASE]
						        | dq_s2_q[SR_SUPPLY] | dq_s2_q[SR_PROTECT];
						// bits 4, 5, 3 and 1 carry the failure kinds
						busy_d  = 1'b0;
						done_ev = 1'b1;
						st_d    = ST_IDLE;
					end
				end
			end
			ST_RST: begin
				// hold the device in reset; it drops its status register
				cnt_d = cnt_q + 4'd1;
				stat_d = 8'h00;
				if (cnt_q == RESET_CYCLES - 4'd1) begin
					pin_d.rp_n = 1'b1;
					cnt_d  = 4'd0;
					busy_d = 1'b0;
					st_d   = ST_IDLE;
				end
			end
			default: st_d = ST_IDLE;
		endcase
		// forced reset from software aborts whatever runs
		if (wr_acc && paddr == REG_CTRL && pwdata[8] && st_q != ST_RST) begin
			pin_d  = '{addr: 23'h0, wdata: 16'h0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe: 1'b0, rp_n: 1'b0};
			cnt_d  = 4'd0;
			busy_d = 1'b1;
			st_d   = ST_RST;
		end
	end

	// =========================================================
	// interrupt registers
	logic [IRQ_W-1:0] ist_q, ist_d, msk_q, msk_d;
	logic             rb_prev_q;
	logic             irq_d;
	always_comb begin
		ist_d = ist_q;
		msk_d = msk_q;
		if (wr_acc && paddr == REG_IRQ_ST)
			ist_d = ist_q & ~pwdata[IRQ_W-1:0];
		if (wr_acc && paddr == REG_IRQ_MSK)
			msk_d = pwdata[IRQ_W-1:0];
		// set wins over a clear in the same cycle
		if (done_ev)
			ist_d[IRQ_DONE] = 1'b1;
		if (err_ev)
			ist_d[IRQ_ERR] = 1'b1;
		if (rb_s2_q && !rb_prev_q)
			ist_d[IRQ_RDY] = 1'b1;
		irq_d = |(ist_d & msk_d);
	end

	// =========================================================
	// apb read side
	logic [31:0] prdata_d;
	always_comb begin
		case (paddr)
			REG_CTRL:    prdata_d = {23'h0, busy_q, 4'h0, op_q};
			REG_ADDR:    prdata_d = {9'h0, addr_q};
			REG_DATA:    prdata_d = {rdata_q, data_q};
			REG_STATUS:  prdata_d = {15'h0, rb_s2_q, 8'h0, stat_q};
			REG_IRQ_ST:  prdata_d = {{(32-IRQ_W){1'b0}}, ist_q};
			REG_IRQ_MSK: prdata_d = {{(32-IRQ_W){1'b0}}, msk_q};
			default:     prdata_d = 32'h00000000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q      <= ST_IDLE;
			pin_q     <= '{addr: 23'h0, wdata: 16'h0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe: 1'b0, rp_n: 1'b0};
			cnt_q     <= 4'd0;
			op_q      <= 4'h0;
			cmd2_q    <= 8'h00;
			two_q     <= 1'b0;
			poll_q    <= 1'b0;
			addr_q    <= 23'h000000;
			data_q    <= 16'h0000;
			rdata_q   <= 16'h0000;
			stat_q    <= 8'h00;
			busy_q    <= 1'b1;
			ist_q     <= '0;
			msk_q     <= '0;
			rb_prev_q <= 1'b1;
			irq       <= 1'b0;
			prdata    <= 32'h00000000;
			pready    <= 1'b0;
			pslverr   <= 1'b0;
		end else begin
			// controller reset also resets the device; release after the hold count
			st_q      <= (st_q == ST_IDLE && !pin_q.rp_n) ? ST_RST : st_d;
			pin_q     <= pin_d;
			cnt_q     <= cnt_d;
			op_q      <= op_d;
			cmd2_q    <= cmd2_d;
			two_q     <= two_d;
			poll_q    <= poll_d;
			addr_q    <= addr_d;
			data_q    <= data_d;
			rdata_q   <= rdata_d;
			stat_q    <= stat_d;
			busy_q    <= busy_d;
			ist_q     <= ist_d;
			msk_q     <= msk_d;
			rb_prev_q <= rb_s2_q;
			irq       <= irq_d;
			prdata    <= prdata_d;
			pready    <= psel & ~penable;
			pslverr   <= 1'b0;
		end
	end

	assign flash_addr              = pin_q.addr;
	assign flash_dq_out            = pin_q.wdata;
	assign flash_dq_oe             = pin_q.dq_oe;
	assign flash_ce_n              = pin_q.ce_n;
	assign flash_oe_n              = pin_q.oe_n;
	assign flash_we_n              = pin_q.we_n;
	assign reset_powerdown_input_n = pin_q.rp_n;
endmodule : flash_host
`default_nettype wire

// *** tb/flash_dev_model.sv ***
// behavioural model of the parallel nor flash seen by the host
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model
	import flash_seq_pkg::*;
(
	// pins
	input  wire logic        clk,
	input  wire logic [22:0] addr,
	input  wire logic [15:0] din,
	input  wire logic        ce_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic        rp_n,
	output logic      [15:0] dout,
	output logic             rdy,
	// fault controls
	input  wire logic        supply_bad,
	input  wire logic [7:0]  busy_len
);
	logic [15:0] mem [256];
	logic [15:0] lat_d, last, val;
	logic [22:0] lat_a;
	logic [7:0]  sr, cnt, c;
	logic        we_q, stat_m, susp, drv;
	logic        perm = 1'b0;
	logic [1:0]  pend;
	assign c = lat_d[7:0];
	// ready/busy floats in suspend and reset; the pull-up then wins
	assign rdy = !(cnt != 8'h00 && !susp && rp_n);
	assign drv = !ce_n && !oe_n;
	assign val = stat_m ? {8'h00, cnt == 8'h00 || susp, sr[6:0]} : mem[addr[7:0]];
	// a released bus toggles each cycle between the inverse of the old value and the old value
	assign dout = drv ? val : ~last;
	always @(posedge clk) last <= dout;
	// ========================================
	// command latch and write state machine
	always @(posedge clk or negedge rp_n) begin
		if (!rp_n) begin
			sr     <= 8'h00;
			cnt    <= 8'h00;
			stat_m <= 1'b0;
			susp   <= 1'b0;
			pend   <= 2'd0;
			we_q   <= 1'b1;
		end else begin
			we_q <= we_n;
			if (!we_n && !ce_n) begin
				lat_d <= din;
				lat_a <= addr;
			end
			if (cnt != 8'h00 && !susp)
				cnt <= cnt - 8'h01;
			if (we_n && !we_q) begin
				stat_m <= 1'b1;
				pend   <= 2'd0;
				if (pend == 2'd1) begin
					cnt <= busy_len;
					if (supply_bad)
						sr <= sr | 8'h18;
					else
						mem[lat_a[7:0]] <= lat_d;
				end else if (pend == 2'd2) begin
					if (c != CMD_LOCK_BLOCK && c != CMD_LOCK_PERM && c != CMD_LOCK_CLEAR)
						sr <= sr | 8'h30;
					else begin
						cnt <= busy_len;
						if (perm && c != CMD_LOCK_PERM)
							sr <= sr | 8'h02;
						else if (supply_bad)
							sr <= sr | (c == CMD_LOCK_CLEAR ? 8'h28 : 8'h18);
						else if (c == CMD_LOCK_PERM)
							perm <= 1'b1;
					end
				end else begin
					case (c)
						CMD_PROG_SETUP, CMD_PROG_SETUP_B: pend <= 2'd1;
						CMD_LOCK_SETUP: pend <= 2'd2;
						CMD_CLEAR_STATUS: sr <= 8'h00;
						CMD_READ_ARRAY: stat_m <= 1'b0;
						CMD_SUSPEND: if (cnt != 8'h00) begin
							susp  <= 1'b1;
							sr[2] <= 1'b1;
						end
						CMD_RESUME: if (susp) begin
							susp  <= 1'b0;
							sr[2] <= 1'b0;
						end
						default: ;
					endcase
				end
			end
		end
	end
endmodule : flash_dev_model
`default_nettype wire

// *** tb/flash_host_chk_chk.sv ***
// assertion checker for the host flash pins and apb answer
`timescale 1ns/1ps
`default_nettype none
module flash_host_chk
	import flash_seq_pkg::*;
(
	// apb
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	// flash pins
	input wire logic [22:0] flash_addr,
	input wire logic [15:0] flash_dq_out,
	input wire logic        flash_dq_oe,
	input wire logic        flash_ce_n,
	input wire logic        flash_oe_n,
	input wire logic        flash_we_n,
	input wire logic        reset_powerdown_input_n
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_write_pulse;
		!flash_we_n [*4] ##1 flash_we_n;
	endsequence
	sequence s_read_pulse;
		!flash_oe_n [*4] ##1 flash_oe_n;
	endsequence
	a_apb_no_wait: assert property (psel && !penable |=> pready)
		else $error("apb access not answered");
	a_we_width: assert property ($fell(flash_we_n) |-> s_write_pulse)
		else $error("write strobe width wrong");
	a_oe_width: assert property ($fell(flash_oe_n) |-> s_read_pulse)
		else $error("read strobe width wrong");
	a_ce_on_strobe: assert property (!flash_we_n || !flash_oe_n |-> !flash_ce_n)
		else $error("strobe without chip enable");
	a_no_contention: assert property (!flash_oe_n |-> !flash_dq_oe)
		else $error("host drives data during read");
	a_write_stable: assert property (!flash_we_n && $past(!flash_we_n) |->
		$stable(flash_dq_out) && $stable(flash_addr) && flash_dq_oe)
		else $error("write data moved in strobe");
	a_reset_hold: assert property ($rose(presetn) |-> !reset_powerdown_input_n [*8])
		else $error("device reset released early");
	a_quiet_reset: assert property (!reset_powerdown_input_n |-> flash_we_n && flash_oe_n)
		else $error("strobe during device reset");
	a_poll_reads: assert property (!flash_we_n && flash_dq_out[7:0] == CMD_READ_STATUS ##1
		flash_we_n |-> ##[1:12] !flash_oe_n)
		else $error("status command not followed by read");
endmodule : flash_host_chk
bind flash_host flash_host_chk i_flash_host_chk (.*);
`default_nettype wire

// *** tb/test_flash_host.sv ***
// self-checking bench for the flash command sequencer host
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module test_flash_host
	import flash_seq_pkg::*;
;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00, busy_len = 8'd20;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, irq, dq_oe, ce_n, oe_n, we_n, rp_n, rdy, supply_bad = 1'b0;
	logic [22:0] faddr;
	logic [15:0] dq_out, dq_in;
	int          err_total = 0, tests_run = 0;
	always #2.5 pclk = ~pclk;
	flash_host i_flash_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .flash_addr(faddr), .flash_dq_out(dq_out), .flash_dq_in(dq_in),
		.flash_dq_oe(dq_oe), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
		.reset_powerdown_input_n(rp_n), .ready_busy_output(rdy));
	flash_dev_model i_flash_dev_model (.clk(pclk), .addr(faddr), .din(dq_out), .ce_n(ce_n),
		.oe_n(oe_n), .we_n(we_n), .rp_n(rp_n), .dout(dq_in), .rdy(rdy), .supply_bad(supply_bad),
		.busy_len(busy_len));
	// ========================================
	// bus tasks and expectations
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// look mid-cycle so pready and prdata are settled, then pass the sampling edge
		do begin
			@(negedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		@(posedge pclk);
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic op(input logic [3:0] o, input logic [7:0] c = 8'h00);
		int n = 0;
		// an op written while busy is dropped, so wait for idle first
		do begin
			apb(1'b0, REG_CTRL, 32'h0);
			n++;
		end while (rd[8] !== 1'b0 && n < 5000);
		n = 0;
		apb(1'b1, REG_CTRL, {16'h0, c, 4'h0, o});
		do begin
			apb(1'b0, REG_CTRL, 32'h0);
			n++;
		end while (rd[8] !== 1'b0 && n < 5000);
	endtask : op
	task automatic st(input logic [7:0] e);
		apb(1'b0, REG_STATUS, 32'h0);
		`CHK(rd[7:0], e)
	endtask : st
	task automatic irq_is(input logic e);
		repeat (2) @(negedge pclk);
		`CHK(irq, e)
		@(posedge pclk);
	endtask : irq_is
	// kind: 0 program, 1 block lock, 2 permanent lock, 3 clear locks
	function automatic logic [7:0] exp_sr(input logic [7:0] p, input int kind, input logic perm, input logic bad);
		logic [7:0] e;
		e = 8'h00;
		if (perm && (kind == 1 || kind == 3))
			e = 8'h02;
		else if (bad)
			e = (kind == 3) ? 8'h28 : 8'h18;
		return p | e | 8'h80;
	endfunction : exp_sr
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict
	initial begin
		#300000;
		err_total++;
		give_verdict();
	end
	// ========================================
	// scenarios
	initial begin
		logic [22:0] a;
		logic [15:0] d;
		logic [7:0]  s;
		int          n;
		logic [3:0]  lop [7] = '{OP_LOCK_BLK, OP_LOCK_CLR, OP_LOCK_BLK, OP_LOCK_CLR, OP_LOCK_PERM,
			OP_LOCK_BLK, OP_LOCK_CLR};
		void'($urandom(47));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		op(OP_POLL);
		st(8'h80);
		apb(1'b0, 8'h20, 32'h0);
		`CHK(rd, 32'h0)
		$display("test reset done");
		s = 8'h80;
		for (int i = 0; i < 6; i++) begin
			a = 23'($urandom_range(255, 1));
			d = 16'($urandom);
			supply_bad <= (i == 2);
			busy_len <= 8'($urandom_range(60, 5));
			apb(1'b1, REG_ADDR, {9'h0, a});
			apb(1'b1, REG_DATA, {16'h0, d});
			op(OP_PROGRAM);
			s = exp_sr(s, 0, 1'b0, i == 2);
			st(s);
			op(OP_READ);
			apb(1'b0, REG_DATA, 32'h0);
			if (i != 2)
				`CHK(rd[31:16], d)
		end
		apb(1'b1, REG_IRQ_MSK, 32'h0);
		irq_is(1'b0);
		apb(1'b1, REG_IRQ_MSK, 32'h3);
		irq_is(1'b1);
		apb(1'b0, REG_IRQ_ST, 32'h0);
		`CHK(rd[1:0], 2'b11)
		apb(1'b1, REG_IRQ_ST, 32'h3);
		irq_is(1'b0);
		op(OP_CLR_STAT);
		op(OP_POLL);
		st(8'h80);
		$display("test program done");
		busy_len <= 8'd200;
		apb(1'b1, REG_ADDR, {9'h0, a ^ 23'h1});
		op(OP_RAW_CMD, CMD_PROG_SETUP);
		op(OP_RAW_CMD, 8'h22);
		op(OP_SUSPEND);
		st(8'h84);
		`CHK(rd[16], 1'b1)
		apb(1'b1, REG_ADDR, {9'h0, a});
		op(OP_READ);
		apb(1'b0, REG_DATA, 32'h0);
		`CHK(rd[31:16], d)
		op(OP_RESUME);
		n = 0;
		// poll until ready before trusting the error bits
		do begin
			op(OP_POLL);
			apb(1'b0, REG_STATUS, 32'h0);
			n++;
		end while (rd[7] !== 1'b1 && n < 100);
		st(8'h80);
		op(OP_SUSPEND);
		st(8'h80);
		$display("test suspend done");
		for (int k = 0; k < 7; k++) begin
			supply_bad <= (k == 2 || k == 3);
			busy_len <= 8'($urandom_range(40, 3));
			op(OP_CLR_STAT);
			op(lop[k]);
			st(exp_sr(8'h00, int'(lop[k]) - 4, k > 4, k == 2 || k == 3));
		end
		op(OP_CLR_STAT);
		op(OP_RAW_CMD, CMD_LOCK_SETUP);
		op(OP_RAW_CMD, 8'h22);
		op(OP_POLL);
		st(8'hb0);
		apb(1'b1, REG_CTRL, 32'h100);
		op(4'h0);
		op(OP_POLL);
		st(8'h80);
		$display("test lock done");
		give_verdict();
	end
endmodule : test_flash_host
`default_nettype wire
